// ### hdl/ldc_pkg.sv
// constants and types for the load driver control block
// Behaviour
// R1 - ctrl reg three bits 3:0 select which high-side driver feeds current sense
// R2 - current sense blanked at least 32 us after a driver switches on
// R3 - with pwm enable set, output equals pwm input and on/off bit
// R4 - outs 1-5,7,9,glass use pwm_in_a; 6 uses pwm_in_b; 8 uses pwm_in_c
// R5 - host keeps pwm off phase at least 300 us
// R6 - half bridge opposite transistor waits cross-current delay after turn-off
// R7 - after delay, turning-off side goes fast off, opposite slews on
// R8 - per-driver recovery bit re-enables overcurrent-shut output after recovery time
// R9 - recovery duty cycle selectable about 12 or 25 percent
// R10 - recovery pulsing repeats at 1.7 kHz or 3 kHz
// R11 - clearing recovery bit during persistent overload latches output off
// R12 - glass target code is six bits at ctrl reg three bits 6:1
// R13 - glass loop enabled only while loop-enable bit 0 is set
// R14 - range limit bit clamps controller output to 1.2 V, same step
// R15 - fast discharge grounds glass node until within margin above target
// R16 - over and under target flags unlatched, valid after filter time
// R17 - follower supply overcurrent switches glass loop off
// R18 - in glass mode pwm gating of glass path output is ignored
// R19 - negative mode bit grounds node, regulates return pin to target
// R20 - host switches return pin low side on for positive control
// R21 - follower gate drive pulled to ground when glass mode inactive
// R22 - host reset low defaults control and config, keeps threshold select
// R23 - overcurrent turns output off, latches diag; recovery auto-clears it
// R24 - all outputs off in passive, uv, ov, thermal shutdown, stuck input
// R25 - pwm inputs synchronised before gating outputs
package ldc_pkg;
   localparam int          NUM_DRV        = 10;  // outs 1..9 plus glass path (index 9)
   localparam int          NUM_HB         = 5;
   localparam int          CLK_HZ         = 10_000_000;
   localparam int          BLANK_US       = 32;
   localparam int          BLANK_CYC      = (BLANK_US * CLK_HZ + 999_999) / 1_000_000;
   localparam int          XCUR_NS        = 2000;
   localparam int          XCUR_CYC       = (XCUR_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int          REC_FAST_HZ    = 3000;
   localparam int          REC_SLOW_HZ    = 1700;
   localparam int          REC_FAST_CYC   = CLK_HZ / REC_FAST_HZ;
   localparam int          REC_SLOW_CYC   = CLK_HZ / REC_SLOW_HZ;
   localparam int          FILT_US        = 64;
   localparam int          FILT_CYC       = FILT_US * (CLK_HZ / 1_000_000);
   localparam int          CNT_W          = 13;
   localparam int          SEL_LSB        = 0;
   localparam int          SEL_W          = 4;
   localparam int          EC_ON_BIT      = 0;
   localparam int          EC_CODE_LSB    = 1;
   localparam int          EC_CODE_W      = 6;
   localparam int          EC_NEG_BIT     = 7;
   localparam int          EC_LIM_BIT     = 5;
   localparam int          ST_OVER_BIT    = 4;
   localparam int          ST_UNDER_BIT   = 5;
   localparam logic [5:0]  EC_LIM_CODE    = 6'h33; // 1.2 V of 1.5 V full scale
   localparam logic [5:0]  EC_MARGIN      = 6'h02;
   localparam int          FOLLOWER_IDX   = 6;     // follower_supply_out supplies the follower
   localparam int          GLASS_IDX      = 9;
   localparam logic [9:0]  PWM_B_MASK     = 10'h020;
   localparam logic [9:0]  PWM_C_MASK     = 10'h080;
   localparam logic [7:0]  CTRL_RST       = 8'h00;
   typedef enum logic [1:0] {LDC_HB_OFF, LDC_HB_WAIT, LDC_HB_HS, LDC_HB_LS} ldc_hb_e;
endpackage : ldc_pkg

// ### hdl/ldc_top.sv
// load driver control: gating, cross-current, recovery, sense select, glass loop control
`timescale 1ns/1ps
module ldc_top
   import ldc_pkg::*;
(
   input  wire logic                 i_sys_clk,           // 10 MHz clock
   input  wire logic                 i_sys_rst,           // sync reset, active high
   input  wire logic                 i_host_reset_out_n,  // host reset output level, low = reset
   input  wire logic [NUM_DRV-1:0]   i_drv_on,            // on/off bits per driver
   input  wire logic [NUM_DRV-1:0]   i_pwm_en,            // pwm enable per driver
   input  wire logic [NUM_DRV-1:0]   i_rec_en,            // overcurrent recovery bit per driver
   input  wire logic                 i_rec_duty_25,       // 1 = 25 % duty, 0 = 12 %
   input  wire logic                 i_rec_fast,          // 1 = 3 kHz, 0 = 1.7 kHz
   input  wire logic [NUM_HB-1:0]    i_hb_low_sel,        // half bridge: 1 = low side drives
   input  wire logic [NUM_DRV-1:0]   i_diag_clr,          // software clear of overcurrent diag
   input  wire logic [NUM_DRV-1:0]   i_overcurrent,       // overcurrent comparator per driver
   input  wire logic [7:0]           i_ctrl3_wr,          // write data, third control register
   input  wire logic                 i_ctrl3_we,          // write strobe
   input  wire logic [7:0]           i_ctrl4_wr,          // write data, fourth control register
   input  wire logic                 i_ctrl4_we,          // write strobe
   input  wire logic                 i_fast_dis_on,       // fast discharge switch command
   input  wire logic                 i_node_above,        // node above target comparator
   input  wire logic                 i_node_below,        // node below target comparator
   input  wire logic                 i_node_near,         // node within margin above target
   input  wire logic                 i_passive,           // passive mode
   input  wire logic                 i_supply_fault,      // under or over voltage
   input  wire logic                 i_thermal_sd,        // either shutdown level
   input  wire logic                 i_din_stuck,         // serial input stuck
   input  wire logic                 i_pwm_in_a,          // external pwm a
   input  wire logic                 i_pwm_in_b,          // external pwm b
   input  wire logic                 i_pwm_in_c,          // external pwm c
   output logic      [NUM_DRV-1:0]   o_drv_out,           // driver on commands (hs side for bridges)
   output logic      [NUM_HB-1:0]    o_hb_ls_out,         // half bridge low-side on
   output logic      [NUM_HB-1:0]    o_hb_fast_off,       // fast turn-off phase
   output logic      [NUM_DRV-1:0]   o_diag_oc,           // latched overcurrent diag
   output logic      [SEL_W-1:0]     o_sense_sel,         // current sense mux select
   output logic                      o_sense_blank,       // current sense blanked
   output logic      [7:0]           o_ctrl3,             // third control register readback
   output logic      [7:0]           o_ctrl4,             // fourth control register readback
   output logic      [EC_CODE_W-1:0] o_glass_dac,         // controller target, clamped
   output logic                      o_glass_loop_on,     // loop running
   output logic                      o_glass_fast_dis,    // node low-side switch on
   output logic                      o_glass_return_reg,  // return pin regulated (negative mode)
   output logic                      o_follower_gate_pd,  // gate drive resistive pull-down
   output logic      [7:0]           o_status4            // fourth status register
);
   logic [2:0]          pa_s1_reg, pa_s2_reg;
   logic [7:0]          ctrl3_reg, ctrl4_reg;
   logic [NUM_DRV-1:0]  diag_reg, on_reg, lock_reg, prev_cmd_reg;
   logic [CNT_W-1:0]    rec_cnt_reg, blank_cnt_reg, ov_cnt_reg, un_cnt_reg;
   logic                rec_phase, force_off, glass_mode, regs_rst;
   logic [NUM_DRV-1:0]  pwm_sel, cmd;
   logic [CNT_W-1:0]    rec_per, rec_on;

   assign regs_rst   = i_sys_rst | ~i_host_reset_out_n;  // see R22
   assign force_off  = i_passive | i_supply_fault | i_thermal_sd | i_din_stuck;  // see R24
   // glass mode drops at once on follower overcurrent, not waiting for the diag latch
   assign glass_mode = ctrl3_reg[EC_ON_BIT] & ~diag_reg[FOLLOWER_IDX]
                       & ~i_overcurrent[FOLLOWER_IDX] & ~force_off;  // see R13, R17

   // two flops per pwm input; only the second stage is used
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         pa_s1_reg <= 3'h0;
         pa_s2_reg <= 3'h0;
      end else begin
         pa_s1_reg <= {i_pwm_in_c, i_pwm_in_b, i_pwm_in_a};  // see R25
         pa_s2_reg <= pa_s1_reg;
      end
   end

   // threshold select lives outside this block, so host reset cannot disturb it
   always_ff @(posedge i_sys_clk) begin
      if (regs_rst) begin
         ctrl3_reg <= CTRL_RST;  // see R22
         ctrl4_reg <= CTRL_RST;
      end else begin
         if (i_ctrl3_we)
            ctrl3_reg <= i_ctrl3_wr;
         if (i_ctrl4_we)
            ctrl4_reg <= i_ctrl4_wr;
      end
   end

   // recovery timebase shared by all drivers
   assign rec_per = i_rec_fast ? CNT_W'(REC_FAST_CYC) : CNT_W'(REC_SLOW_CYC);  // see R10
   assign rec_on  = i_rec_duty_25 ? (rec_per >> 2) : (rec_per >> 3);  // see R9
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst)
         rec_cnt_reg <= '0;
      else if (rec_cnt_reg >= rec_per - 1'b1)
         rec_cnt_reg <= '0;
      else
         rec_cnt_reg <= rec_cnt_reg + 1'b1;
   end
   assign rec_phase = (rec_cnt_reg < rec_on);

   genvar g;
   generate
      for (g = 0; g < NUM_DRV; g++) begin : g_drv
         logic pwm_g, gate_ok;
         assign pwm_g = PWM_B_MASK[g] ? pa_s2_reg[1] : (PWM_C_MASK[g] ? pa_s2_reg[2] : pa_s2_reg[0]);  // see R4
         assign gate_ok = (g == GLASS_IDX && glass_mode) ? 1'b1 : pwm_g;  // see R18
         assign pwm_sel[g] = (i_pwm_en[g] && !(g == GLASS_IDX && glass_mode)) ? gate_ok : 1'b1;
         // recovery pulses the output at the programmed duty; locked off otherwise
         assign cmd[g] = i_drv_on[g] & pwm_sel[g] & ~force_off & ~lock_reg[g]
                         & (~diag_reg[g] | (i_rec_en[g] & rec_phase));  // see R3, R8, R24
      end
   endgenerate

   // overcurrent latch, recovery pulsing and lock after recovery is dropped
   always_ff @(posedge i_sys_clk) begin
      if (regs_rst) begin
         diag_reg <= '0;
         lock_reg <= '0;
      end else begin
         for (int k = 0; k < NUM_DRV; k++) begin
            if (i_overcurrent[k] && on_reg[k])
               diag_reg[k] <= 1'b1;  // see R23
            else if (i_rec_en[k] && !i_overcurrent[k] && rec_phase && on_reg[k])
               diag_reg[k] <= 1'b0;  // see R23
            else if (i_diag_clr[k])
               diag_reg[k] <= 1'b0;
            if (!i_rec_en[k] && diag_reg[k] && i_overcurrent[k])
               lock_reg[k] <= 1'b1;  // see R11
            else if (i_diag_clr[k] && !i_overcurrent[k])
               lock_reg[k] <= 1'b0;
         end
      end
   end

   // half bridges: opposite side waits for the cross-current delay
   generate
      for (g = 0; g < NUM_HB; g++) begin : g_hb
         ldc_hb_e         st_reg;
         logic [CNT_W-1:0] xc_reg;
         always_ff @(posedge i_sys_clk) begin
            if (i_sys_rst) begin
               st_reg <= LDC_HB_OFF;
               xc_reg <= '0;
            end else begin
               case (st_reg)
                  LDC_HB_OFF: begin
                     if (cmd[g]) begin
                        st_reg <= i_hb_low_sel[g] ? LDC_HB_LS : LDC_HB_HS;
                     end
                  end
                  LDC_HB_HS: begin
                     if (!cmd[g] || i_hb_low_sel[g]) begin
                        st_reg <= LDC_HB_WAIT;  // see R6
                        xc_reg <= CNT_W'(XCUR_CYC);
                     end
                  end
                  LDC_HB_LS: begin
                     if (!cmd[g] || !i_hb_low_sel[g]) begin
                        st_reg <= LDC_HB_WAIT;  // see R6
                        xc_reg <= CNT_W'(XCUR_CYC);
                     end
                  end
                  LDC_HB_WAIT: begin
                     if (xc_reg > 1)
                        xc_reg <= xc_reg - 1'b1;
                     else
                        st_reg <= LDC_HB_OFF;  // see R7
                  end
                  default: st_reg <= LDC_HB_OFF;
               endcase
            end
         end
         always_ff @(posedge i_sys_clk) begin
            if (i_sys_rst) begin
               on_reg[g]        <= 1'b0;
               o_hb_ls_out[g]   <= 1'b0;
               o_hb_fast_off[g] <= 1'b0;
            end else begin
               on_reg[g]        <= (st_reg == LDC_HB_HS) && cmd[g] && !i_hb_low_sel[g];
               o_hb_ls_out[g]   <= (st_reg == LDC_HB_LS) && cmd[g] && i_hb_low_sel[g];
               o_hb_fast_off[g] <= (st_reg == LDC_HB_WAIT) && (xc_reg <= 1);  // see R7
            end
         end
      end
      for (g = NUM_HB; g < NUM_DRV; g++) begin : g_hs
         always_ff @(posedge i_sys_clk) begin
            if (i_sys_rst)
               on_reg[g] <= 1'b0;
            else
               on_reg[g] <= cmd[g];
         end
      end
   endgenerate

   // blank sense after any driver switch-on; a change of sense select does not restart it
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         prev_cmd_reg  <= '0;
         blank_cnt_reg <= '0;
      end else begin
         prev_cmd_reg <= on_reg;
         if (|(on_reg & ~prev_cmd_reg))
            blank_cnt_reg <= CNT_W'(BLANK_CYC);  // see R2
         else if (blank_cnt_reg != '0)
            blank_cnt_reg <= blank_cnt_reg - 1'b1;
      end
   end

   // over/under flags need a stable comparator for the filter time
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst || !glass_mode) begin
         ov_cnt_reg <= '0;
         un_cnt_reg <= '0;
      end else begin
         ov_cnt_reg <= !i_node_above ? '0 : (ov_cnt_reg < CNT_W'(FILT_CYC) ? ov_cnt_reg + 1'b1 : ov_cnt_reg);
         un_cnt_reg <= !i_node_below ? '0 : (un_cnt_reg < CNT_W'(FILT_CYC) ? un_cnt_reg + 1'b1 : un_cnt_reg);
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_drv_out          <= '0;
         o_diag_oc          <= '0;
         o_sense_sel        <= '0;
         o_sense_blank      <= 1'b1;
         o_ctrl3            <= '0;
         o_ctrl4            <= '0;
         o_glass_dac        <= '0;
         o_glass_loop_on    <= 1'b0;
         o_glass_fast_dis   <= 1'b0;
         o_glass_return_reg <= 1'b0;
         o_follower_gate_pd <= 1'b1;
         o_status4          <= '0;
      end else begin
         o_drv_out   <= on_reg;
         o_diag_oc   <= diag_reg;
         o_sense_sel <= ctrl3_reg[SEL_LSB +: SEL_W];  // see R1
         o_sense_blank <= (blank_cnt_reg != '0) || (|(on_reg & ~prev_cmd_reg));  // see R2
         o_ctrl3 <= ctrl3_reg;
         o_ctrl4 <= ctrl4_reg;
         if (ctrl4_reg[EC_LIM_BIT] && ctrl3_reg[EC_CODE_LSB +: EC_CODE_W] > EC_LIM_CODE)
            o_glass_dac <= EC_LIM_CODE;  // see R14
         else
            o_glass_dac <= ctrl3_reg[EC_CODE_LSB +: EC_CODE_W];  // see R12
         o_glass_loop_on    <= glass_mode;  // see R13, R17
         // fast discharge ends when node is within margin; negative mode holds node low
         o_glass_fast_dis   <= glass_mode && ((i_fast_dis_on && !i_node_near)
                                              || ctrl3_reg[EC_NEG_BIT]);  // see R15, R19
         o_glass_return_reg <= glass_mode && ctrl3_reg[EC_NEG_BIT];  // see R19
         o_follower_gate_pd <= !glass_mode;  // see R21
         o_status4 <= '0;
         o_status4[ST_OVER_BIT]  <= ov_cnt_reg >= CNT_W'(FILT_CYC);  // see R16
         o_status4[ST_UNDER_BIT] <= un_cnt_reg >= CNT_W'(FILT_CYC);  // see R16
      end
   end
endmodule : ldc_top

// ### verif/ldc_top_props.sv
// concurrent checks on the ports of the load driver control block
`timescale 1ns/1ps
module ldc_top_props
   import ldc_pkg::*;
(
   input  wire logic [0:0]           i_sys_clk,          // clock
   input  wire logic                 i_sys_rst,          // sync reset
   input  wire logic                 i_passive,          // fault input
   input  wire logic                 i_supply_fault,     // fault input
   input  wire logic                 i_thermal_sd,       // fault input
   input  wire logic                 i_din_stuck,        // fault input
   input  wire logic                 i_node_above,       // over comparator
   input  wire logic [NUM_DRV-1:0]   i_rec_en,           // recovery bits
   input  wire logic [NUM_DRV-1:0]   o_drv_out,          // driver commands
   input  wire logic [NUM_HB-1:0]    o_hb_ls_out,        // bridge low sides
   input  wire logic [NUM_DRV-1:0]   o_diag_oc,          // overcurrent diag
   input  wire logic [SEL_W-1:0]     o_sense_sel,        // sense select
   input  wire logic                 o_sense_blank,      // sense blanking
   input  wire logic [7:0]           o_ctrl3,            // ctrl3 readback
   input  wire logic [7:0]           o_ctrl4,            // ctrl4 readback
   input  wire logic [EC_CODE_W-1:0] o_glass_dac,        // clamped target
   input  wire logic                 o_glass_loop_on,    // loop running
   input  wire logic                 o_follower_gate_pd, // gate pull-down
   input  wire logic [7:0]           o_status4           // status register
);
   int                   blank_cnt;
   int                   above_cnt;
   int                   hs_off_cnt;
   wire logic            fault = i_passive | i_supply_fault | i_thermal_sd | i_din_stuck;
   wire logic [5:0]      code  = o_ctrl3[EC_CODE_LSB +: EC_CODE_W];
   wire logic [5:0]      dac_exp = (o_ctrl4[EC_LIM_BIT] && code > EC_LIM_CODE) ? EC_LIM_CODE : code;
   // reset loads blank_cnt full so the blank that reset itself holds is never judged short
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         blank_cnt  <= BLANK_CYC;
         above_cnt  <= 0;
         hs_off_cnt <= 0;
      end else begin
         blank_cnt  <= o_sense_blank ? blank_cnt + 1 : 0;
         above_cnt  <= i_node_above ? above_cnt + 1 : 0;
         hs_off_cnt <= o_drv_out[0] ? 0 : hs_off_cnt + 1;
      end
   end
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   property p_sense_sel; o_sense_sel == o_ctrl3[SEL_LSB +: SEL_W]; endproperty
   a_sense_sel: assert property (p_sense_sel) else $error("sense select differs from ctrl3");
   property p_blank_on; (|(o_drv_out & ~$past(o_drv_out))) |-> o_sense_blank; endproperty
   a_blank_on: assert property (p_blank_on) else $error("sense not blanked at driver turn-on");
   property p_blank_len; $fell(o_sense_blank) |-> blank_cnt >= BLANK_CYC; endproperty
   a_blank_len: assert property (p_blank_len) else $error("sense blank too short");
   property p_force_off; fault |-> ##2 (o_drv_out == '0 && o_hb_ls_out == '0); endproperty
   a_force_off: assert property (p_force_off) else $error("driver on during fault");
   property p_loop_en; o_glass_loop_on |-> (o_ctrl3[EC_ON_BIT] || $past(o_ctrl3[EC_ON_BIT])); endproperty
   a_loop_en: assert property (p_loop_en) else $error("loop on without enable bit");
   property p_gate_pd; !o_glass_loop_on |-> o_follower_gate_pd; endproperty
   a_gate_pd: assert property (p_gate_pd) else $error("gate drive not pulled down");
   property p_dac; (o_glass_loop_on && $stable(o_ctrl3) && $stable(o_ctrl4)) [*3] |-> o_glass_dac == dac_exp; endproperty
   a_dac: assert property (p_dac) else $error("glass target code wrong");
   property p_over_filt; $rose(o_status4[ST_OVER_BIT]) |-> above_cnt >= FILT_CYC; endproperty
   a_over_filt: assert property (p_over_filt) else $error("over flag before filter time");
   property p_over_drop; $fell(i_node_above) |-> ##[0:4] !o_status4[ST_OVER_BIT]; endproperty
   a_over_drop: assert property (p_over_drop) else $error("over flag held after node dropped");
   property p_xcur; $rose(o_hb_ls_out[0]) |-> hs_off_cnt >= XCUR_CYC; endproperty
   a_xcur: assert property (p_xcur) else $error("low side on inside cross-current delay");
   property p_diag_off; o_diag_oc[5] && !i_rec_en[5] && !$past(i_rec_en[5]) |-> ##1 !o_drv_out[5]; endproperty
   a_diag_off: assert property (p_diag_off) else $error("output on with diag latched");
   c_loop: cover property ($rose(o_glass_loop_on));
   c_ls_on: cover property ($rose(o_hb_ls_out[0]));
   c_over: cover property ($rose(o_status4[ST_OVER_BIT]));
endmodule : ldc_top_props
bind ldc_top ldc_top_props chk_u (.*);

// ### verif/ldc_host_pwm.sv
// host side pwm source: three staggered lines with long off phases
`timescale 1ns/1ps
module ldc_host_pwm #(
   parameter int PERIOD = 8000, // cycles per pwm period
   parameter int ON_CYC = 1000  // high time of each line
) (
   input  wire logic i_sys_clk,      // clock
   input  wire logic i_sys_rst,      // reset holds cnt at 0: line a high, b and c low
   output logic      o_pwm_in_a = 0, // pwm a
   output logic      o_pwm_in_b = 0, // pwm b
   output logic      o_pwm_in_c = 0  // pwm c
);
   int cnt = 0;
   // the phases never overlap, so each output can be told apart from its own line
   always @(posedge i_sys_clk) begin
      #1;
      cnt = (i_sys_rst || cnt == PERIOD - 1) ? 0 : cnt + 1;
      o_pwm_in_a = cnt < ON_CYC;
      o_pwm_in_b = cnt >= 2 * ON_CYC && cnt < 3 * ON_CYC;
      o_pwm_in_c = cnt >= 4 * ON_CYC && cnt < 5 * ON_CYC;
   end
endmodule : ldc_host_pwm

// ### verif/load_driver_control_tb_top.sv
// self-checking bench for the load driver control block
`timescale 1ns/1ps
module load_driver_control_tb_top
   import ldc_pkg::*;
;
   logic i_sys_clk = 0, i_sys_rst = 1, i_host_reset_out_n = 1, i_ctrl3_we = 0, i_ctrl4_we = 0;
   logic i_rec_duty_25 = 1, i_rec_fast = 1, i_fast_dis_on = 0, i_node_above = 0, i_node_below = 0;
   logic i_node_near = 0, oc_follow = 0, o_sense_blank, o_glass_loop_on, o_glass_fast_dis;
   logic o_glass_return_reg, o_follower_gate_pd, i_pwm_in_a, i_pwm_in_b, i_pwm_in_c;
   logic [NUM_DRV-1:0] i_drv_on = '0, i_pwm_en = '0, i_rec_en = '0, i_diag_clr = '0, oc_set = '0;
   logic [NUM_DRV-1:0] o_drv_out, o_diag_oc;
   logic [NUM_HB-1:0]  i_hb_low_sel = '0, o_hb_ls_out, o_hb_fast_off;
   logic [7:0]         i_ctrl3_wr = 0, i_ctrl4_wr = 0, o_ctrl3, o_ctrl4, o_status4;
   logic [3:0]         flt = 0, o_sense_sel;
   logic [5:0]         o_glass_dac;
   wire logic          i_passive, i_supply_fault, i_thermal_sd, i_din_stuck;
   wire logic [NUM_DRV-1:0] i_overcurrent = oc_set | ({NUM_DRV{oc_follow}} & o_drv_out);
   wire logic [6:0]    watch = {o_hb_fast_off[0], o_hb_ls_out[0], o_drv_out[0], o_drv_out[5],
                                i_pwm_in_c, i_pwm_in_b, i_pwm_in_a};
   int                 failures = 0, comparisons = 0, waited, hi;
   assign {i_din_stuck, i_thermal_sd, i_supply_fault, i_passive} = flt;
   ldc_top dut_u (.*);
   ldc_host_pwm host_u (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .o_pwm_in_a(i_pwm_in_a),
                        .o_pwm_in_b(i_pwm_in_b), .o_pwm_in_c(i_pwm_in_c));
   initial begin
      forever #50 i_sys_clk = ~i_sys_clk;
   end
   task automatic report_and_stop;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : report_and_stop
   task automatic cyc(input int k);
      repeat (k) @(posedge i_sys_clk);
      #1;
   endtask : cyc
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one bounded wait for every watched line; waited accumulates so callers can time spans
   task automatic wait_sig(input int k, input logic lvl);
      for (int n = 0; watch[k] !== lvl; n++) begin
         if (n == 12000) begin
            failures++;
            report_and_stop;
         end
         cyc(1);
         waited++;
      end
   endtask : wait_sig
   task automatic wr(input logic four, input logic [7:0] d);
      i_ctrl3_wr = d;
      i_ctrl4_wr = d;
      i_ctrl3_we = !four;
      i_ctrl4_we = four;
      cyc(1);
      i_ctrl3_we = 0;
      i_ctrl4_we = 0;
      cyc(3);
   endtask : wr
   initial begin
      cyc(4);
      i_sys_rst = 0;
      chk({o_sense_blank, o_follower_gate_pd, o_glass_loop_on, o_drv_out}, 13'h1800);
      wr(0, 8'h7f);
      chk({o_sense_sel, o_glass_dac, o_glass_loop_on, o_follower_gate_pd}, {4'hf, 6'h3f, 2'b10});
      wr(1, 8'h20);
      chk(o_glass_dac, EC_LIM_CODE);
      wr(0, 8'h2b);
      chk({o_sense_sel, o_glass_dac}, {4'hb, 6'h15});
      i_host_reset_out_n = 0;
      cyc(1);
      i_host_reset_out_n = 1;
      cyc(3);
      chk({o_ctrl3, o_ctrl4, o_glass_loop_on, o_follower_gate_pd}, {CTRL_RST, CTRL_RST, 2'b01});
      wr(0, 8'h81);
      chk({o_glass_fast_dis, o_glass_return_reg}, 2'b11);
      wr(0, 8'h01); // positive control: the host keeps the element grounded
      i_fast_dis_on = 1;
      cyc(3);
      chk(o_glass_fast_dis, 1'b1);
      i_node_near = 1;
      cyc(3);
      chk(o_glass_fast_dis, 1'b0);
      i_fast_dis_on = 0;
      i_node_above = 1;
      cyc(FILT_CYC - 20);
      chk(o_status4, 8'h00);
      cyc(40);
      chk(o_status4, 8'h10);
      i_node_above = 0;
      i_node_below = 1;
      cyc(4);
      chk(o_status4, 8'h00);
      cyc(FILT_CYC + 20);
      chk(o_status4, 8'h20);
      i_node_below = 0;
      i_drv_on[FOLLOWER_IDX] = 1;
      oc_set[FOLLOWER_IDX] = 1;
      cyc(5);
      chk({o_glass_loop_on, o_drv_out[FOLLOWER_IDX], o_diag_oc[FOLLOWER_IDX]}, 3'b001);
      oc_set = '0;
      cyc(4);
      chk(o_drv_out[FOLLOWER_IDX], 1'b0);
      i_diag_clr[FOLLOWER_IDX] = 1;
      cyc(1);
      i_diag_clr = '0;
      wr(0, 8'h01);
      i_drv_on = '1;
      i_pwm_en = '1;
      wait_sig(0, 0);
      wait_sig(0, 1);
      cyc(6);
      chk({o_sense_blank, o_drv_out}, 11'h75f);
      wait_sig(1, 1);
      cyc(6);
      chk(o_drv_out, 10'h220);
      wait_sig(2, 1);
      cyc(6);
      chk(o_drv_out, 10'h280);
      i_pwm_en = '0;
      i_drv_on = 10'h020;
      i_rec_en[5] = 1;
      oc_follow = 1;
      // the first rise may fall mid-period, so only a later full period is timed; fast mode, then slow
      for (int m = 1; m >= 0; m--) begin
         i_rec_fast = m;
         i_rec_duty_25 = m;
         wait_sig(3, 1);
         wait_sig(3, 0);
         wait_sig(3, 1);
         waited = 0;
         wait_sig(3, 0);
         hi = m ? REC_FAST_CYC : REC_SLOW_CYC;
         chk(waited >= hi / (m ? 4 : 8) - 10 && waited <= hi / (m ? 4 : 8) + 10, 1'b1);
         wait_sig(3, 1);
         chk(waited >= hi - 10 && waited <= hi + 10, 1'b1);
      end
      i_rec_en[5] = 0;
      cyc(10);
      hi = 0;
      repeat (2 * REC_FAST_CYC) begin
         cyc(1);
         if (o_drv_out[5] !== 1'b0)
            hi++;
      end
      chk(hi, 0);
      oc_follow = 0;
      i_diag_clr[5] = 1;
      cyc(1);
      i_diag_clr = '0;
      cyc(4);
      chk({o_drv_out[5], o_diag_oc[5]}, 2'b10);
      for (int k = 0; k < 4; k++) begin
         flt = 4'h1 << k;
         cyc(4);
         chk(o_drv_out, 10'h000);
         flt = 0;
         cyc(4);
         chk(o_drv_out[5], 1'b1);
      end
      i_drv_on[0] = 1;
      cyc(4);
      i_hb_low_sel[0] = 1;
      waited = 0;
      wait_sig(6, 1);
      chk({waited >= XCUR_CYC, o_hb_ls_out[0]}, 2'b10);
      wait_sig(5, 1);
      chk(o_drv_out[0], 1'b0);
      report_and_stop;
   end
endmodule : load_driver_control_tb_top
